// ---- sdpd_pkg.sv ----
/*
 * constants for the command decoder and power-down control of a DDR2-style dram.
 * assumes a single 100 MHz clock; pins are sampled on the rising edge.
 */
package sdpd_pkg;
  localparam int NUM_BANKS = 8;
  localparam int BANK_W = 3;
  localparam int LAT_W = 4;
  // exit latencies in clocks, plain defaults
  localparam logic [LAT_W-1:0] IDLE_EXIT_LAT = 4'h2;
  localparam logic [LAT_W-1:0] FAST_EXIT_LAT = 4'h2;
  localparam logic [LAT_W-1:0] SLOW_EXIT_LAT = 4'h7;
  localparam logic [LAT_W-1:0] LAT_ZERO = 4'h0;
  localparam logic [LAT_W-1:0] LAT_ONE = 4'h1;
  localparam logic [NUM_BANKS-1:0] BANKS_IDLE = 8'h00;

  typedef enum logic [3:0] {
    SDPD_CMD_NOP, SDPD_CMD_DESEL, SDPD_CMD_MRS, SDPD_CMD_REF, SDPD_CMD_SREF,
    SDPD_CMD_PRE, SDPD_CMD_PREA, SDPD_CMD_ACT, SDPD_CMD_WR, SDPD_CMD_WRA,
    SDPD_CMD_RD, SDPD_CMD_RDA, SDPD_CMD_PDE, SDPD_CMD_PDX, SDPD_CMD_NONE
  } sdpd_cmd_t;

  typedef enum logic [1:0] {
    SDPD_PD_NONE, SDPD_PD_PRECHARGE, SDPD_PD_ACTIVE_FAST, SDPD_PD_ACTIVE_SLOW
  } sdpd_pd_t;
endpackage : sdpd_pkg

// ---- sdpd_core.sv ----
/*
 * command decoder with clock-enable power-down entry and exit control.
 * assumes the controller obeys cke hold times and entry restrictions.
 */
`timescale 1ns/1ps
`default_nettype none
module sdpd_core (
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // command pins
  input wire logic cke,
  input wire logic cs_n,
  input wire logic ras_n,
  input wire logic cas_n,
  input wire logic we_n,
  input wire logic [sdpd_pkg::BANK_W-1:0] bank_addr,
  input wire logic auto_precharge_bit,
  // mode register field
  input wire logic pd_exit_select,
  // decoded command and state
  output logic [3:0] cmd_code,
  output logic cmd_valid,
  output logic [sdpd_pkg::NUM_BANKS-1:0] bank_open,
  output logic [1:0] pd_mode,
  output logic in_self_refresh,
  output logic buffers_enabled,
  output logic dll_enabled,
  output logic exit_busy
);
  logic cke_q;
  logic [sdpd_pkg::NUM_BANKS-1:0] open_q, open_d;
  sdpd_pkg::sdpd_pd_t pd_q, pd_d;
  logic sref_q, sref_d;
  logic [sdpd_pkg::LAT_W-1:0] exit_q, exit_d;
  sdpd_pkg::sdpd_cmd_t cmd_w;

  // decode from pin states at this edge and previous cke
  wire is_desel = cs_n;
  wire is_nop = !cs_n && ras_n && cas_n && we_n;
  wire idle_cmd = is_desel || is_nop;
  wire any_open = open_q != sdpd_pkg::BANKS_IDLE;
  wire pd_now = (pd_q != sdpd_pkg::SDPD_PD_NONE) || sref_q;

  always_comb begin
    cmd_w = sdpd_pkg::SDPD_CMD_NONE;
    if (!cke_q) begin
      if (cke && idle_cmd) cmd_w = sdpd_pkg::SDPD_CMD_PDX;
    end else if (!cke) begin
      if (idle_cmd) cmd_w = sdpd_pkg::SDPD_CMD_PDE;
      else if (!cs_n && !ras_n && !cas_n && we_n) cmd_w = sdpd_pkg::SDPD_CMD_SREF;
    end else if (is_desel) cmd_w = sdpd_pkg::SDPD_CMD_DESEL;
    else begin
      unique case ({ras_n, cas_n, we_n})
        3'h7: cmd_w = sdpd_pkg::SDPD_CMD_NOP;
        3'h0: cmd_w = sdpd_pkg::SDPD_CMD_MRS;
        3'h1: cmd_w = sdpd_pkg::SDPD_CMD_REF;
        3'h2: cmd_w = auto_precharge_bit ? sdpd_pkg::SDPD_CMD_PREA
                                         : sdpd_pkg::SDPD_CMD_PRE;
        3'h3: cmd_w = sdpd_pkg::SDPD_CMD_ACT;
        3'h4: cmd_w = auto_precharge_bit ? sdpd_pkg::SDPD_CMD_WRA
                                         : sdpd_pkg::SDPD_CMD_WR;
        3'h5: cmd_w = auto_precharge_bit ? sdpd_pkg::SDPD_CMD_RDA
                                         : sdpd_pkg::SDPD_CMD_RD;
        default: cmd_w = sdpd_pkg::SDPD_CMD_NONE;
      endcase
    end
  end

  // per-bank open tracking; autoprecharge closes the bank
  generate
    for (genvar b = 0; b < sdpd_pkg::NUM_BANKS; b++) begin : g_bank
      wire hit = bank_addr == sdpd_pkg::BANK_W'(b);
      always_comb begin
        open_d[b] = open_q[b];
        if (cmd_w == sdpd_pkg::SDPD_CMD_ACT && hit) open_d[b] = 1'b1;
        else if (cmd_w == sdpd_pkg::SDPD_CMD_PREA) open_d[b] = 1'b0;
        else if (hit && (cmd_w == sdpd_pkg::SDPD_CMD_PRE || cmd_w == sdpd_pkg::SDPD_CMD_WRA ||
                 cmd_w == sdpd_pkg::SDPD_CMD_RDA)) open_d[b] = 1'b0;
      end
    end
  endgenerate

  // power-down kind and exit latency
  always_comb begin
    pd_d = pd_q;
    sref_d = sref_q;
    exit_d = (exit_q != sdpd_pkg::LAT_ZERO) ? exit_q - sdpd_pkg::LAT_ONE : exit_q;
    if (cmd_w == sdpd_pkg::SDPD_CMD_SREF) sref_d = 1'b1;
    else if (cmd_w == sdpd_pkg::SDPD_CMD_PDE) begin
      if (!any_open) pd_d = sdpd_pkg::SDPD_PD_PRECHARGE;
      else if (pd_exit_select) pd_d = sdpd_pkg::SDPD_PD_ACTIVE_SLOW;
      else pd_d = sdpd_pkg::SDPD_PD_ACTIVE_FAST;
    end else if (cmd_w == sdpd_pkg::SDPD_CMD_PDX) begin
      pd_d = sdpd_pkg::SDPD_PD_NONE;
      sref_d = 1'b0;
      unique case (pd_q)
        sdpd_pkg::SDPD_PD_ACTIVE_FAST: exit_d = sdpd_pkg::FAST_EXIT_LAT;
        sdpd_pkg::SDPD_PD_ACTIVE_SLOW: exit_d = sdpd_pkg::SLOW_EXIT_LAT;
        default: exit_d = sdpd_pkg::IDLE_EXIT_LAT;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      cke_q <= 1'b0;
      open_q <= sdpd_pkg::BANKS_IDLE;
      pd_q <= sdpd_pkg::SDPD_PD_NONE;
      sref_q <= 1'b0;
      exit_q <= sdpd_pkg::LAT_ZERO;
    end else begin
      cke_q <= cke;
      open_q <= open_d;
      pd_q <= pd_d;
      sref_q <= sref_d;
      exit_q <= exit_d;
    end
  end

  // outputs, registered; buffers off in power-down, dll kept only in fast exit
  always_ff @(posedge clk) begin
    if (!resetn) begin
      cmd_code <= sdpd_pkg::SDPD_CMD_NONE;
      cmd_valid <= 1'b0;
      bank_open <= sdpd_pkg::BANKS_IDLE;
      pd_mode <= sdpd_pkg::SDPD_PD_NONE;
      in_self_refresh <= 1'b0;
      buffers_enabled <= 1'b1;
      dll_enabled <= 1'b1;
      exit_busy <= 1'b0;
    end else begin
      cmd_code <= cmd_w;
      cmd_valid <= cmd_w != sdpd_pkg::SDPD_CMD_NONE;
      bank_open <= open_d;
      pd_mode <= pd_d;
      in_self_refresh <= sref_d;
      buffers_enabled <= (pd_d == sdpd_pkg::SDPD_PD_NONE) && !sref_d;
      dll_enabled <= (pd_d == sdpd_pkg::SDPD_PD_NONE || pd_d == sdpd_pkg::SDPD_PD_ACTIVE_FAST)
                     && !sref_d;
      exit_busy <= exit_d != sdpd_pkg::LAT_ZERO;
    end
  end

  // assertions
  chk_pd_entry_kind: assert property (@(posedge clk) disable iff (!resetn)
    (cke_q && !cke && idle_cmd && !pd_now) |=>
      (pd_mode == (($past(any_open)) ? ($past(pd_exit_select) ? 2'h3 : 2'h2) : 2'h1)))
    else $error("power-down kind wrong");
  chk_pd_exit_clear: assert property (@(posedge clk) disable iff (!resetn)
    (pd_q != sdpd_pkg::SDPD_PD_NONE && !cke_q && cke && idle_cmd) |=>
      (pd_mode == 2'h0 && buffers_enabled && exit_busy))
    else $error("power-down exit not taken");
  sequence s_slow_exit;
    pd_q == sdpd_pkg::SDPD_PD_ACTIVE_SLOW && !cke_q && cke && idle_cmd;
  endsequence
  chk_slow_exit_lat: assert property (@(posedge clk) disable iff (!resetn)
    s_slow_exit ##1 cke [*6] |=> exit_busy)
    else $error("slow exit latency too short");
  chk_dll_fast_on: assert property (@(posedge clk) disable iff (!resetn)
    (pd_mode == 2'h2) |-> (dll_enabled && !buffers_enabled))
    else $error("dll off in fast exit power-down");
  chk_dll_off_pre: assert property (@(posedge clk) disable iff (!resetn)
    (pd_mode == 2'h1 || pd_mode == 2'h3) |-> !dll_enabled)
    else $error("dll on in deep power-down");
  chk_nop_decode: assert property (@(posedge clk) disable iff (!resetn)
    (cke_q && cke && !cs_n && ras_n && cas_n && we_n) |=> cmd_code == 4'h0)
    else $error("nop decoded wrong");
  chk_desel_decode: assert property (@(posedge clk) disable iff (!resetn)
    (cke_q && cke && cs_n) |=> (cmd_code == 4'h1 && $stable(bank_open)))
    else $error("deselect decoded wrong");
  chk_act_opens: assert property (@(posedge clk) disable iff (!resetn)
    (cke_q && cke && !cs_n && !ras_n && cas_n && we_n) |=> bank_open[$past(bank_addr)])
    else $error("activate did not open bank");
  chk_prea_closes: assert property (@(posedge clk) disable iff (!resetn)
    (cke_q && cke && !cs_n && !ras_n && cas_n && !we_n && auto_precharge_bit) |=>
      bank_open == sdpd_pkg::BANKS_IDLE)
    else $error("precharge all left bank open");
  chk_sref_entry: assert property (@(posedge clk) disable iff (!resetn)
    (cke_q && !cke && !cs_n && !ras_n && !cas_n && we_n) |=> in_self_refresh)
    else $error("self-refresh not entered");
  // exit counts below assume the default idle and fast latencies of two clocks
  sequence s_fast_exit;
    pd_q == sdpd_pkg::SDPD_PD_ACTIVE_FAST && !cke_q && cke && idle_cmd;
  endsequence
  sequence s_idle_exit;
    (pd_q == sdpd_pkg::SDPD_PD_PRECHARGE || sref_q) && !cke_q && cke && idle_cmd;
  endsequence
  sequence s_busy_two;
    exit_busy ##1 exit_busy ##1 !exit_busy;
  endsequence
  chk_fast_exit_lat: assert property (@(posedge clk) disable iff (!resetn)
    s_fast_exit |=> s_busy_two)
    else $error("fast exit latency wrong");
  chk_idle_exit_lat: assert property (@(posedge clk) disable iff (!resetn)
    s_idle_exit |=> s_busy_two)
    else $error("idle exit latency wrong");
  chk_slow_exit_end: assert property (@(posedge clk) disable iff (!resetn)
    s_slow_exit |-> ##8 !exit_busy)
    else $error("slow exit latency too long");
  chk_pd_maintain: assert property (@(posedge clk) disable iff (!resetn)
    (!cke_q && !cke) |=> (!cmd_valid && $stable(pd_mode) && $stable(bank_open)))
    else $error("state changed while powered down");
  chk_illegal_code: assert property (@(posedge clk) disable iff (!resetn)
    (cke_q && cke && !cs_n && ras_n && cas_n && !we_n) |=>
      (!cmd_valid && cmd_code == sdpd_pkg::SDPD_CMD_NONE))
    else $error("reserved pattern decoded");
  chk_sref_exit: assert property (@(posedge clk) disable iff (!resetn)
    (sref_q && !cke_q && cke && idle_cmd) |=>
      (!in_self_refresh && cmd_code == sdpd_pkg::SDPD_CMD_PDX))
    else $error("self-refresh exit not taken");
  chk_sref_gating: assert property (@(posedge clk) disable iff (!resetn)
    in_self_refresh |-> (!buffers_enabled && !dll_enabled))
    else $error("buffers live in self-refresh");
  chk_pre_closes: assert property (@(posedge clk) disable iff (!resetn)
    (cke_q && cke && !cs_n && !ras_n && cas_n && !we_n && !auto_precharge_bit) |=>
      !bank_open[$past(bank_addr)])
    else $error("precharge left bank open");
  chk_pde_decode: assert property (@(posedge clk) disable iff (!resetn)
    (cke_q && !cke && idle_cmd) |=>
      (cmd_code == sdpd_pkg::SDPD_CMD_PDE && !buffers_enabled))
    else $error("power-down entry not decoded");
endmodule : sdpd_core
`default_nettype wire

// ---- sdpd_ctl_model.sv ----
/* controller-side pin driver for the command decoder bench.
   assumes callers sit just after a rising clock edge. */
`timescale 1ns/1ps
`default_nettype none
module sdpd_ctl_model (
  // command pins
  output var logic cke,
  output var logic cs_n,
  output var logic ras_n,
  output var logic cas_n,
  output var logic we_n,
  output var logic auto_precharge_bit,
  output var logic [2:0] bank_addr
);
  // idle controller: cke high with nop
  initial {cke, cs_n, ras_n, cas_n, we_n, auto_precharge_bit, bank_addr} = 9'h170;
  // pins change once per call and hold until the next call
  // calls come only just after an edge, so cke never drops asynchronously
  // the dll is taken as locked at every power-down entry
  task put(input logic [5:0] p, input logic [2:0] ba);
    {cke, cs_n, ras_n, cas_n, we_n, auto_precharge_bit} = p;
    bank_addr = ba;
  endtask : put
endmodule : sdpd_ctl_model
`default_nettype wire

// ---- sdpd_core_tb.sv ----
/* self-checking bench for the command decoder and power-down control.
   assumes the controller model drives the pins and a 100 MHz clock. */
`timescale 1ns/1ps
`default_nettype none
module sdpd_core_tb;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic pd_exit_select = 1'b0;
  logic cke, cs_n, ras_n, cas_n, we_n, auto_precharge_bit;
  logic [2:0] bank_addr;
  logic [2:0] ba = 3'h3;
  logic [3:0] cmd_code;
  logic cmd_valid, in_self_refresh, buffers_enabled, dll_enabled, exit_busy;
  logic [7:0] bank_open;
  logic [1:0] pd_mode;
  int fails = 0;
  int samples_checked = 0;
  int cycles = 0;
  // idle clocks after reads and writes before entry; plain default
  localparam int BURST_SETTLE = 16;
  // rows: cs_n, ras_n, cas_n, we_n, auto_precharge_bit, expected code
  logic [8:0] rows [0:10] = '{9'h002, 9'h023, 9'h067, 9'h088, 9'h0AA, 9'h045,
                              9'h056, 9'h099, 9'h0BB, 9'h0E0, 9'h101};
  always #5 clk = ~clk;
  sdpd_ctl_model u_ctl (.cke(cke), .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n),
    .auto_precharge_bit(auto_precharge_bit), .bank_addr(bank_addr));
  sdpd_core dut (.clk(clk), .resetn(resetn), .cke(cke), .cs_n(cs_n), .ras_n(ras_n),
    .cas_n(cas_n), .we_n(we_n), .bank_addr(bank_addr),
    .auto_precharge_bit(auto_precharge_bit), .pd_exit_select(pd_exit_select),
    .cmd_code(cmd_code), .cmd_valid(cmd_valid), .bank_open(bank_open), .pd_mode(pd_mode),
    .in_self_refresh(in_self_refresh), .buffers_enabled(buffers_enabled),
    .dll_enabled(dll_enabled), .exit_busy(exit_busy));
  task check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fails++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  task wrap_up;
    $display("checked %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : wrap_up
  task step(input logic [5:0] p);
    u_ctl.put(p, ba);
    @(posedge clk);
    #1;
  endtask : step
  task pd_cycle(input logic [1:0] mode, input logic dll, input logic [3:0] lat);
    int n;
    step(6'b001110);
    check("entry code", cmd_code, 8'h0C);
    check("pd kind", pd_mode, mode);
    check("buffers", buffers_enabled, 1'b0);
    check("dll", dll_enabled, dll);
    repeat (3) step(6'b000000);
    check("pd held", pd_mode, mode);
    check("pd quiet", cmd_valid, 1'b0);
    step(6'b101110);
    check("exit code", cmd_code, 8'h0D);
    check("pd cleared", pd_mode, 8'h00);
    check("buffers back", buffers_enabled, 1'b1);
    n = 0;
    while (exit_busy === 1'b1 && n < 20) begin
      n++;
      step(6'b101110);
    end
    check("exit latency", 8'(n), lat);
    repeat (3) step(6'b101110);
    $display("power-down kind %0d done", mode);
  endtask : pd_cycle
  always @(posedge clk) begin
    cycles++;
    if (cycles == 1000) begin
      fails++;
      wrap_up();
    end
  end
  initial begin
    repeat (16) @(posedge clk);
    #1;
    check("reset code", cmd_code, 8'h0E);
    check("reset banks", bank_open, 8'h00);
    check("reset valid", cmd_valid, 1'b0);
    check("reset pd", pd_mode, 8'h00);
    check("reset buffers", buffers_enabled, 1'b1);
    check("reset dll", dll_enabled, 1'b1);
    check("reset busy", exit_busy, 1'b0);
    check("reset sref", in_self_refresh, 1'b0);
    $display("reset values done");
    resetn = 1'b1;
    repeat (4) step(6'b101110);
    for (int i = 0; i < 11; i++) begin
      step({1'b1, rows[i][8:4]});
      check("decode", cmd_code, rows[i][3:0]);
      check("valid", cmd_valid, 1'b1);
    end
    $display("decode table done");
    step(6'b101100);
    check("reserved code", cmd_code, 8'h0E);
    check("reserved valid", cmd_valid, 1'b0);
    repeat (BURST_SETTLE) step(6'b101110);
    $display("reserved pattern done");
    pd_cycle(sdpd_pkg::SDPD_PD_PRECHARGE, 1'b0, sdpd_pkg::IDLE_EXIT_LAT);
    ba = 3'h5;
    step(6'b100110);
    check("bank opened", bank_open, 8'h20);
    pd_cycle(sdpd_pkg::SDPD_PD_ACTIVE_FAST, 1'b1, sdpd_pkg::FAST_EXIT_LAT);
    pd_exit_select = 1'b1;
    pd_cycle(sdpd_pkg::SDPD_PD_ACTIVE_SLOW, 1'b0, sdpd_pkg::SLOW_EXIT_LAT);
    step(6'b100101);
    check("all closed", bank_open, 8'h00);
    step(6'b000010);
    check("sref entry", cmd_code, 8'h04);
    check("sref level", in_self_refresh, 1'b1);
    check("sref buffers", buffers_enabled, 1'b0);
    check("sref dll", dll_enabled, 1'b0);
    repeat (3) step(6'b000000);
    step(6'b101110);
    check("sref exit", cmd_code, 8'h0D);
    check("sref left", in_self_refresh, 1'b0);
    check("sref exit busy", exit_busy, 1'b1);
    repeat (8) step(6'b101110);
    $display("self-refresh done");
    step(6'b100110);
    resetn = 1'b0;
    step(6'b101110);
    check("mid reset banks", bank_open, 8'h00);
    check("mid reset code", cmd_code, 8'h0E);
    check("mid reset valid", cmd_valid, 1'b0);
    check("mid reset busy", exit_busy, 1'b0);
    check("mid reset buffers", buffers_enabled, 1'b1);
    resetn = 1'b1;
    repeat (4) step(6'b101110);
    check("after reset", pd_mode, 8'h00);
    $display("mid-run reset done");
    wrap_up();
  end
endmodule : sdpd_core_tb
`default_nettype wire
